// >>> include/cam_pkg.sv
// Package of constants shared by the counter unit and its controller.
package cam_pkg;
  // ==========================================================
  // Special function register addresses
  localparam logic [7:0] CAM_CTRL_ADDR = 8'hd8;
  localparam logic [7:0] CAM_CMODE_ADDR = 8'hd9;
  localparam logic [7:0] CAM_MMODE_ADDR = 8'hda;
  localparam logic [7:0] CAM_CNTL_ADDR = 8'he9;
  localparam logic [7:0] CAM_CNTH_ADDR = 8'hf9;
  localparam logic [7:0] CAM_CPL_ADDR = 8'hea;
  localparam logic [7:0] CAM_CPH_ADDR = 8'hfa;
  // ==========================================================
  // Control and counter mode register fields
  localparam int CAM_CF_BIT = 7;
  localparam int CAM_CR_BIT = 6;
  localparam int CAM_CCF_BIT = 0;
  localparam int CAM_ECF_BIT = 0;
  // ==========================================================
  // Module mode register fields
  localparam int CAM_PWM16_BIT = 7;
  localparam int CAM_ECOM_BIT = 6;
  localparam int CAM_TOG_BIT = 2;
  localparam int CAM_PWM_BIT = 1;
  localparam int CAM_ECCF_BIT = 0;
  // ==========================================================
  // Reset values and counter limits
  localparam logic [7:0] CAM_SFR_RESET = 8'h00;
  localparam logic [7:0] CAM_LOW_MAX = 8'hff;
  localparam logic [15:0] CAM_CNT_MAX = 16'hffff;
  // ==========================================================
  // Controller AXI4-Lite register offsets and fields
  localparam logic [3:0] CAM_CMD_OFS = 4'h0;
  localparam logic [3:0] CAM_STAT_OFS = 4'h4;
  localparam logic [3:0] CAM_ISTAT_OFS = 4'h8;
  localparam logic [3:0] CAM_IMASK_OFS = 4'hc;
  localparam int CAM_CMD_WR_BIT = 16;
  localparam int CAM_CMD_RD_BIT = 17;
  localparam int CAM_BUSY_BIT = 8;
  localparam logic [1:0] CAM_RESP_OKAY = 2'b00;
  localparam logic [1:0] CAM_RESP_SLVERR = 2'b10;
  typedef enum logic [1:0] {
    CAM_IDLE = 2'b00,
    CAM_STROBE = 2'b01,
    CAM_CAPTURE = 2'b11
  } cam_state_t;
endpackage

// >>> include/cam_sfr_if.sv
// Interface joining the counter unit and its controller.
`timescale 1ns/1ps
`default_nettype none
interface cam_sfr_if;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic wr;
  logic rd;
  logic [7:0] rdata;
  logic irq;
  modport dev(input addr, input wdata, input wr, input rd,
              output rdata, output irq);
  modport ctl(output addr, output wdata, output wr, output rd,
              input rdata, input irq);
endinterface
`default_nettype wire

// >>> core/cam_counter_unit.sv
// Counter array unit with one waveform-generating compare module.
`timescale 1ns/1ps
`default_nettype none
module cam_counter_unit
  import cam_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic timebase_tick,
  cam_sfr_if.dev sfr,
  output logic module_output_pin
);
  logic [15:0] cnt;
  logic [15:0] next_cnt;
  logic counter_wrap_flag;
  logic next_counter_wrap_flag;
  logic counter_run;
  logic next_counter_run;
  logic module_match_flag;
  logic next_module_match_flag;
  logic wrap_irq_enable;
  logic next_wrap_irq_enable;
  logic [7:0] module_mode_reg;
  logic [7:0] next_module_mode_reg;
  logic [7:0] compare_low_byte;
  logic [7:0] next_compare_low_byte;
  logic [7:0] compare_high_byte;
  logic [7:0] next_compare_high_byte;
  logic pin;
  logic next_pin;
  logic [7:0] rdata;
  logic [7:0] next_rdata;
  logic irq;
  logic next_irq;

  // ==========================================================
  // Read multiplexer
  function automatic logic [7:0] read_mux(input logic [7:0] a);
    logic [7:0] v;
    v = 8'h00;
    unique case (a)
      CAM_CTRL_ADDR: begin
        v[CAM_CF_BIT] = counter_wrap_flag;
        v[CAM_CR_BIT] = counter_run;
        v[CAM_CCF_BIT] = module_match_flag;
      end
      CAM_CMODE_ADDR: v[CAM_ECF_BIT] = wrap_irq_enable;
      CAM_MMODE_ADDR: v = module_mode_reg;
      CAM_CNTL_ADDR: v = cnt[7:0];
      CAM_CNTH_ADDR: v = cnt[15:8];
      CAM_CPL_ADDR: v = compare_low_byte;
      CAM_CPH_ADDR: v = compare_high_byte;
      default: v = 8'h00;
    endcase
    return v;
  endfunction

  // ==========================================================
  // Counter, compare and register update
  always_comb begin
    logic adv;
    logic [15:0] cnt_inc;
    logic lo_ovf;
    logic wrap;
    logic ecom;
    logic freq_mode;
    logic pwm8_mode;
    logic pwm16_mode;
    logic [7:0] cmp8;
    logic match8;
    logic match16;
    adv = 1'b0;
    cnt_inc = 16'h0000;
    lo_ovf = 1'b0;
    wrap = 1'b0;
    ecom = 1'b0;
    freq_mode = 1'b0;
    pwm8_mode = 1'b0;
    pwm16_mode = 1'b0;
    cmp8 = 8'h00;
    match8 = 1'b0;
    match16 = 1'b0;
    next_cnt = cnt;
    next_counter_wrap_flag = counter_wrap_flag;
    next_counter_run = counter_run;
    next_module_match_flag = module_match_flag;
    next_wrap_irq_enable = wrap_irq_enable;
    next_module_mode_reg = module_mode_reg;
    next_compare_low_byte = compare_low_byte;
    next_compare_high_byte = compare_high_byte;
    next_pin = pin;
    next_rdata = rdata;
    adv = counter_run && timebase_tick;
    cnt_inc = cnt + 16'h0001;
    lo_ovf = adv && (cnt[7:0] == CAM_LOW_MAX);
    wrap = adv && (cnt == CAM_CNT_MAX);
    ecom = module_mode_reg[CAM_ECOM_BIT];
    freq_mode = ecom && module_mode_reg[CAM_TOG_BIT]
                && module_mode_reg[CAM_PWM_BIT];
    pwm8_mode = ecom && module_mode_reg[CAM_PWM_BIT]
                && !module_mode_reg[CAM_TOG_BIT]
                && !module_mode_reg[CAM_PWM16_BIT];
    pwm16_mode = ecom && module_mode_reg[CAM_PWM_BIT]
                 && !module_mode_reg[CAM_TOG_BIT]
                 && module_mode_reg[CAM_PWM16_BIT];
    // A match compares against the count being entered, so a reload
    // at the low-byte wrap is already seen by that same compare.
    cmp8 = (pwm8_mode && lo_ovf) ? compare_high_byte : compare_low_byte;
    match8 = adv && (cnt_inc[7:0] == cmp8);
    match16 = adv && (cnt_inc == {compare_high_byte, compare_low_byte});
    if (adv) begin
      next_cnt = cnt_inc;
    end
    if (freq_mode && match8) begin
      next_pin = !pin;
      next_compare_low_byte = compare_low_byte + compare_high_byte;
    end
    if (pwm8_mode) begin
      if (lo_ovf) begin
        next_compare_low_byte = compare_high_byte;
      end
      // Set wins over clear so a zero byte holds the pin high.
      if (match8) begin
        next_pin = 1'b1;
      end else if (lo_ovf) begin
        next_pin = 1'b0;
      end
    end
    if (pwm16_mode) begin
      if (match16) begin
        next_pin = 1'b1;
      end else if (wrap) begin
        next_pin = 1'b0;
      end
    end
    if (module_mode_reg[CAM_PWM_BIT] && !ecom) begin
      next_pin = 1'b0;
    end
    if (sfr.wr) begin
      unique case (sfr.addr)
        CAM_CTRL_ADDR: begin
          next_counter_wrap_flag = sfr.wdata[CAM_CF_BIT];
          next_counter_run = sfr.wdata[CAM_CR_BIT];
          next_module_match_flag = sfr.wdata[CAM_CCF_BIT];
        end
        CAM_CMODE_ADDR: next_wrap_irq_enable = sfr.wdata[CAM_ECF_BIT];
        CAM_MMODE_ADDR: next_module_mode_reg = sfr.wdata;
        CAM_CNTL_ADDR: next_cnt[7:0] = sfr.wdata;
        CAM_CNTH_ADDR: next_cnt[15:8] = sfr.wdata;
        CAM_CPL_ADDR: begin
          next_compare_low_byte = sfr.wdata;
          next_module_mode_reg[CAM_ECOM_BIT] = 1'b0;
        end
        CAM_CPH_ADDR: begin
          next_compare_high_byte = sfr.wdata;
          next_module_mode_reg[CAM_ECOM_BIT] = 1'b1;
        end
        default: begin
        end
      endcase
    end
    if (wrap) begin
      next_counter_wrap_flag = 1'b1;
    end
    if (ecom && (pwm16_mode ? match16 : match8)) begin
      next_module_match_flag = 1'b1;
    end
    if (sfr.rd) begin
      next_rdata = read_mux(sfr.addr);
    end
    next_irq = (counter_wrap_flag && wrap_irq_enable)
               || (module_match_flag && module_mode_reg[CAM_ECCF_BIT]);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt <= 16'h0000;
      counter_wrap_flag <= 1'b0;
      counter_run <= 1'b0;
      module_match_flag <= 1'b0;
      wrap_irq_enable <= 1'b0;
      module_mode_reg <= CAM_SFR_RESET;
      compare_low_byte <= CAM_SFR_RESET;
      compare_high_byte <= CAM_SFR_RESET;
      pin <= 1'b0;
      rdata <= 8'h00;
      irq <= 1'b0;
    end else if (ce) begin
      cnt <= next_cnt;
      counter_wrap_flag <= next_counter_wrap_flag;
      counter_run <= next_counter_run;
      module_match_flag <= next_module_match_flag;
      wrap_irq_enable <= next_wrap_irq_enable;
      module_mode_reg <= next_module_mode_reg;
      compare_low_byte <= next_compare_low_byte;
      compare_high_byte <= next_compare_high_byte;
      pin <= next_pin;
      rdata <= next_rdata;
      irq <= next_irq;
    end
  end

  assign sfr.rdata = rdata;
  assign sfr.irq = irq;
  assign module_output_pin = pin;
endmodule
`default_nettype wire

// >>> core/cam_controller.sv
// AXI4-Lite controller that drives the counter unit register bus.
`timescale 1ns/1ps
`default_nettype none
module cam_controller
  import cam_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic irq,
  cam_sfr_if.ctl sfr
);
  cam_state_t state, next_state;
  logic aw_got, next_aw_got, w_got, next_w_got;
  logic [3:0] waddr, next_waddr;
  logic [31:0] wdat, next_wdat;
  logic awready, next_awready, wready, next_wready;
  logic bvalid, next_bvalid, arready, next_arready, rvalid, next_rvalid;
  logic [1:0] bresp, next_bresp, rresp, next_rresp;
  logic [31:0] rdata, next_rdata;
  logic [7:0] addr, next_addr, sdata, next_sdata, rdbuf, next_rdbuf;
  logic wr, next_wr, rd, next_rd, is_write, next_is_write;
  logic [1:0] istat, next_istat, imask, next_imask;
  logic irq_q, next_irq_q;

  function automatic logic mapped(input logic [3:0] a);
    return (a == CAM_CMD_OFS) || (a == CAM_STAT_OFS)
           || (a == CAM_ISTAT_OFS) || (a == CAM_IMASK_OFS);
  endfunction

  // ==========================================================
  // Bus slave, command sequencer and interrupt status
  always_comb begin
    logic done;
    logic [31:0] rv;
    done = 1'b0;
    rv = 32'h0000_0000;
    next_state = state;
    next_aw_got = aw_got;
    next_w_got = w_got;
    next_waddr = waddr;
    next_wdat = wdat;
    next_bvalid = bvalid;
    next_bresp = bresp;
    next_rvalid = rvalid;
    next_rresp = rresp;
    next_rdata = rdata;
    next_addr = addr;
    next_sdata = sdata;
    next_rdbuf = rdbuf;
    next_wr = 1'b0;
    next_rd = 1'b0;
    next_is_write = is_write;
    next_istat = istat;
    next_imask = imask;
    unique case (state)
      CAM_IDLE: begin
      end
      CAM_STROBE: begin
        next_state = is_write ? CAM_IDLE : CAM_CAPTURE;
        done = is_write;
      end
      CAM_CAPTURE: begin
        next_rdbuf = sfr.rdata;
        next_state = CAM_IDLE;
        done = 1'b1;
      end
      default: next_state = CAM_IDLE;
    endcase
    if (s_axi_awvalid && awready) begin
      next_aw_got = 1'b1;
      next_waddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready) begin
      next_w_got = 1'b1;
      next_wdat = s_axi_wdata;
    end
    if (bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    if (aw_got && w_got && !bvalid) begin
      next_aw_got = 1'b0;
      next_w_got = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = mapped(waddr) ? CAM_RESP_OKAY : CAM_RESP_SLVERR;
      if (waddr == CAM_CMD_OFS && state == CAM_IDLE
          && (wdat[CAM_CMD_WR_BIT] || wdat[CAM_CMD_RD_BIT])) begin
        next_addr = wdat[7:0];
        next_sdata = wdat[15:8];
        next_is_write = wdat[CAM_CMD_WR_BIT];
        next_wr = wdat[CAM_CMD_WR_BIT];
        next_rd = !wdat[CAM_CMD_WR_BIT];
        next_state = CAM_STROBE;
      end
      if (waddr == CAM_IMASK_OFS) begin
        next_imask = wdat[1:0];
      end
    end
    if (rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
    if (s_axi_arvalid && arready) begin
      unique case (s_axi_araddr)
        CAM_STAT_OFS: begin
          rv[7:0] = rdbuf;
          rv[CAM_BUSY_BIT] = (state != CAM_IDLE);
        end
        CAM_ISTAT_OFS: begin
          rv[1:0] = istat;
          next_istat = 2'b00;
        end
        CAM_IMASK_OFS: rv[1:0] = imask;
        default: rv = 32'h0000_0000;
      endcase
      next_rvalid = 1'b1;
      next_rdata = rv;
      next_rresp = mapped(s_axi_araddr) ? CAM_RESP_OKAY : CAM_RESP_SLVERR;
    end
    // Events set after the read clear so a same-cycle event survives.
    if (sfr.irq) begin
      next_istat[0] = 1'b1;
    end
    if (done) begin
      next_istat[1] = 1'b1;
    end
    next_awready = !next_aw_got && !next_bvalid;
    next_wready = !next_w_got && !next_bvalid;
    next_arready = !next_rvalid;
    next_irq_q = |(istat & imask);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= CAM_IDLE;
      aw_got <= 1'b0;
      w_got <= 1'b0;
      waddr <= 4'h0;
      wdat <= 32'h0000_0000;
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= CAM_RESP_OKAY;
      arready <= 1'b0;
      rvalid <= 1'b0;
      rresp <= CAM_RESP_OKAY;
      rdata <= 32'h0000_0000;
      addr <= 8'h00;
      sdata <= 8'h00;
      rdbuf <= 8'h00;
      wr <= 1'b0;
      rd <= 1'b0;
      is_write <= 1'b0;
      istat <= 2'b00;
      imask <= 2'b00;
      irq_q <= 1'b0;
    end else if (ce) begin
      state <= next_state;
      aw_got <= next_aw_got;
      w_got <= next_w_got;
      waddr <= next_waddr;
      wdat <= next_wdat;
      awready <= next_awready;
      wready <= next_wready;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      arready <= next_arready;
      rvalid <= next_rvalid;
      rresp <= next_rresp;
      rdata <= next_rdata;
      addr <= next_addr;
      sdata <= next_sdata;
      rdbuf <= next_rdbuf;
      wr <= next_wr;
      rd <= next_rd;
      is_write <= next_is_write;
      istat <= next_istat;
      imask <= next_imask;
      irq_q <= next_irq_q;
    end
  end

  assign s_axi_awready = awready;
  assign s_axi_wready = wready;
  assign s_axi_bvalid = bvalid;
  assign s_axi_bresp = bresp;
  assign s_axi_arready = arready;
  assign s_axi_rvalid = rvalid;
  assign s_axi_rresp = rresp;
  assign s_axi_rdata = rdata;
  assign irq = irq_q;
  assign sfr.addr = addr;
  assign sfr.wdata = sdata;
  assign sfr.wr = wr;
  assign sfr.rd = rd;
endmodule
`default_nettype wire

// >>> verification/cam_sfr_properties.sv
// Checker for the register link between the controller and the unit.
`timescale 1ns/1ps
`default_nettype none
module cam_sfr_properties
  import cam_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  input wire logic irq,
  input wire logic module_output_pin
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ==========================================================
  // Shadow copies of the mode, run and wrap interrupt enable bits.
  logic [7:0] mmode, next_mmode;
  logic run, next_run, wrap_en, next_wrap_en;
  always_comb begin
    next_mmode = mmode;
    next_run = run;
    next_wrap_en = wrap_en;
    if (wr && addr == CAM_MMODE_ADDR) next_mmode = wdata;
    if (wr && addr == CAM_CPL_ADDR) next_mmode[CAM_ECOM_BIT] = 1'b0;
    if (wr && addr == CAM_CPH_ADDR) next_mmode[CAM_ECOM_BIT] = 1'b1;
    if (wr && addr == CAM_CTRL_ADDR) next_run = wdata[CAM_CR_BIT];
    if (wr && addr == CAM_CMODE_ADDR) next_wrap_en = wdata[0];
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mmode <= 8'h00;
      run <= 1'b0;
      wrap_en <= 1'b0;
    end else begin
      mmode <= next_mmode;
      run <= next_run;
      wrap_en <= next_wrap_en;
    end
  end
  // ==========================================================
  // Properties.
  property p_wr_pulse;
    wr |=> !wr;
  endproperty
  a_wr_pulse: assert property (p_wr_pulse)
    else $error("write strobe longer than one cycle");
  property p_rd_pulse;
    rd |=> !rd;
  endproperty
  a_rd_pulse: assert property (p_rd_pulse)
    else $error("read strobe longer than one cycle");
  property p_strobe_excl;
    !(wr && rd);
  endproperty
  a_strobe_excl: assert property (p_strobe_excl)
    else $error("read and write strobes together");
  property p_unused_zero;
    rd && addr == CAM_CTRL_ADDR |=> rdata[5:1] == 5'h00;
  endproperty
  a_unused_zero: assert property (p_unused_zero)
    else $error("unused control bits read nonzero");
  property p_mode_read;
    rd && addr == CAM_MMODE_ADDR |=> rdata == $past(mmode);
  endproperty
  a_mode_read: assert property (p_mode_read)
    else $error("module mode readback wrong");
  property p_run_read;
    rd && addr == CAM_CTRL_ADDR |=> rdata[CAM_CR_BIT] == $past(run);
  endproperty
  a_run_read: assert property (p_run_read)
    else $error("run bit readback wrong");
  property p_zero_duty;
    (mmode[CAM_PWM_BIT] && !mmode[CAM_ECOM_BIT]) [*3] |-> !module_output_pin;
  endproperty
  a_zero_duty: assert property (p_zero_duty)
    else $error("pin high with compare disabled");
  property p_irq_quiet;
    (!wrap_en && !mmode[CAM_ECCF_BIT]) [*3] |-> !irq;
  endproperty
  a_irq_quiet: assert property (p_irq_quiet)
    else $error("interrupt with all sources disabled");
  c_pin_rise: cover property ($rose(module_output_pin));
  c_irq_rise: cover property ($rose(irq));
  c_ctl_read: cover property (rd && addr == CAM_CTRL_ADDR);
endmodule
`default_nettype wire

// >>> verification/cam_counter_array_waveform_modes_bench.sv
// Self-checking bench for the controller and counter unit pair.
`timescale 1ns/1ps
`default_nettype none
module cam_counter_array_waveform_modes_bench
  import cam_pkg::*;
;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic tick = 1'b1;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, irq, pin;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  int fail_count = 0;
  int samples_checked = 0;
  cam_sfr_if u_sfr();
  cam_counter_unit u_cam_counter_unit(.aclk(aclk), .aresetn(aresetn),
    .ce(1'b1), .timebase_tick(tick), .sfr(u_sfr), .module_output_pin(pin));
  cam_controller u_cam_controller(.aclk(aclk), .aresetn(aresetn), .ce(1'b1),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .irq(irq), .sfr(u_sfr));
  cam_sfr_properties u_props(.aclk(aclk), .aresetn(aresetn),
    .addr(u_sfr.addr), .wdata(u_sfr.wdata), .wr(u_sfr.wr), .rd(u_sfr.rd),
    .rdata(u_sfr.rdata), .irq(u_sfr.irq), .module_output_pin(pin));
  initial begin
    forever #4 aclk = ~aclk;
  end
  // ==========================================================
  // Reporting and bus tasks.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    $display("checks=%0d mismatches=%0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic axi_write(input logic [3:0] a, input logic [31:0] d,
                           output logic [1:0] resp);
    bit got;
    got = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int n = 0; n < 64 && !got; n++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) begin
        got = 1;
        resp = bresp;
        bready <= 1'b0;
      end
    end
    if (!got) begin
      check(32'h0, 32'h1);
      final_report();
    end
    @(posedge aclk);
  endtask
  task automatic axi_read(input logic [3:0] a, output logic [31:0] d);
    bit got;
    got = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int n = 0; n < 64 && !got; n++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) begin
        got = 1;
        d = rdata;
        rready <= 1'b0;
      end
    end
    if (!got) begin
      check(32'h0, 32'h1);
      final_report();
    end
    @(posedge aclk);
  endtask
  task automatic sfr_cmd(input logic [1:0] op, input logic [7:0] a,
                         input logic [7:0] d, output logic [7:0] q);
    logic [31:0] st;
    logic [1:0] r;
    axi_write(CAM_CMD_OFS, {14'h0, op, d, a}, r);
    for (int n = 0; n < 20; n++) begin
      axi_read(CAM_STAT_OFS, st);
      q = st[7:0];
      if (st[CAM_BUSY_BIT] === 1'b0) return;
    end
    check(32'h0, 32'h1);
    final_report();
  endtask
  task automatic wr_sfr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    sfr_cmd(2'b01, a, d, q);
  endtask
  // Slow mode gives a tick every other cycle, so the window holds exactly
  // 256 counts; the last pass restores the steady tick for later tests.
  task automatic measure(input bit slow, output int hi, output int tg);
    logic prev;
    hi = 0;
    tg = 0;
    prev = pin;
    if (slow) tick <= 1'b0;
    for (int i = 0; i < 512; i++) begin
      @(posedge aclk);
      hi += int'(pin === 1'b1);
      tg += int'(pin !== prev);
      prev = pin;
      if (slow) tick <= (i == 511) || !tick;
    end
  endtask
  task automatic wait_high(input bit on_irq, input int lim);
    for (int n = 0; (on_irq ? irq : pin) !== 1'b1; n++) begin
      if (n == lim) begin
        check(32'h0, 32'h1);
        final_report();
      end
      @(posedge aclk);
    end
  endtask
  task automatic pulse_len(output int hi);
    wait_high(1'b0, 600);
    hi = 0;
    for (int n = 0; n < 40 && pin === 1'b1; n++) begin
      @(posedge aclk);
      hi++;
    end
  endtask
  // ==========================================================
  // Scenarios.
  task automatic t_regs();
    logic [7:0] v;
    logic [1:0] r;
    logic [31:0] s;
    sfr_cmd(2'b10, CAM_CTRL_ADDR, 8'h00, v);
    check(v, CAM_SFR_RESET);
    wr_sfr(CAM_CTRL_ADDR, 8'h20);
    sfr_cmd(2'b10, CAM_CTRL_ADDR, 8'h00, v);
    check(v, 8'h00);
    axi_write(4'h2, 32'h0, r);
    check(r, CAM_RESP_SLVERR);
    axi_read(4'h2, s);
    check(s, 32'h0);
    check(rresp, CAM_RESP_SLVERR);
    $display("test regs done");
  endtask
  task automatic t_pwm8();
    logic [7:0] v;
    logic [7:0] duty [3] = '{8'h00, 8'hc0, 8'hff};
    int hi, tg;
    wr_sfr(CAM_CTRL_ADDR, 8'h40);
    wr_sfr(CAM_MMODE_ADDR, 8'h42);
    wr_sfr(CAM_CPL_ADDR, 8'h00);
    sfr_cmd(2'b10, CAM_MMODE_ADDR, 8'h00, v);
    check(v, 8'h02);
    measure(1'b0, hi, tg);
    check(hi, 0);
    foreach (duty[i]) begin
      wr_sfr(CAM_CPH_ADDR, duty[i]);
      repeat (300) @(posedge aclk);
      measure(1'b0, hi, tg);
      check(hi, 2 * (256 - duty[i]));
    end
    sfr_cmd(2'b10, CAM_MMODE_ADDR, 8'h00, v);
    check(v, 8'h42);
    $display("test pwm8 done");
  endtask
  task automatic t_freq();
    logic [7:0] half [2] = '{8'h04, 8'h00};
    int hi, tg;
    wr_sfr(CAM_MMODE_ADDR, 8'h46);
    foreach (half[i]) begin
      wr_sfr(CAM_CPL_ADDR, 8'h00);
      wr_sfr(CAM_CPH_ADDR, half[i]);
      repeat (300) @(posedge aclk);
      measure(1'b0, hi, tg);
      check(tg, 512 / (half[i] == 0 ? 256 : half[i]));
    end
    measure(1'b1, hi, tg);
    check(tg, 1);
    $display("test freq done");
  endtask
  task automatic t_pwm16();
    logic [7:0] v;
    logic [31:0] s;
    logic [1:0] r;
    int hi;
    wr_sfr(CAM_CTRL_ADDR, 8'h00);
    wr_sfr(CAM_CNTL_ADDR, 8'h00);
    wr_sfr(CAM_CNTH_ADDR, 8'hff);
    wr_sfr(CAM_MMODE_ADDR, 8'h82);
    wr_sfr(CAM_CPL_ADDR, 8'hf8);
    wr_sfr(CAM_CPH_ADDR, 8'hff);
    wr_sfr(CAM_CMODE_ADDR, 8'h01);
    axi_write(CAM_IMASK_OFS, 32'h1, r);
    wr_sfr(CAM_CTRL_ADDR, 8'h40);
    pulse_len(hi);
    check(hi, 8);
    // A new duty word goes in only once the unit interrupt (wrap or match) is seen.
    wr_sfr(CAM_MMODE_ADDR, 8'hc3);
    wait_high(1'b1, 40);
    wr_sfr(CAM_CPL_ADDR, 8'hf0);
    wr_sfr(CAM_CPH_ADDR, 8'hff);
    wr_sfr(CAM_CNTH_ADDR, 8'hff);
    pulse_len(hi);
    check(hi, 16);
    repeat (4) @(posedge aclk);
    check(irq, 1'b1);
    sfr_cmd(2'b10, CAM_CTRL_ADDR, 8'h00, v);
    check(v, 8'hc1);
    axi_write(CAM_IMASK_OFS, 32'h0, r);
    repeat (2) @(posedge aclk);
    check(irq, 1'b0);
    wr_sfr(CAM_CTRL_ADDR, 8'h00);
    axi_read(CAM_ISTAT_OFS, s);
    axi_read(CAM_ISTAT_OFS, s);
    check(s, 32'h0);
    axi_write(CAM_IMASK_OFS, 32'h1, r);
    repeat (2) @(posedge aclk);
    check(irq, 1'b0);
    wr_sfr(CAM_CNTL_ADDR, 8'h55);
    repeat (20) @(posedge aclk);
    sfr_cmd(2'b10, CAM_CNTL_ADDR, 8'h00, v);
    check(v, 8'h55);
    $display("test pwm16 done");
  endtask
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_regs();
    t_pwm8();
    t_freq();
    t_pwm16();
    final_report();
  end
endmodule
`default_nettype wire
